/* hdl/srq_regs.vh */
// Register offsets, field positions and reset values of the service request block
`ifndef SRQ_REGS_VH
`define SRQ_REGS_VH

`define OFS_STATUS_BYTE     8'h00
`define OFS_SRQ_ENABLE      8'h04
`define OFS_STD_EVENT       8'h08
`define OFS_STD_ENABLE      8'h0C
`define OFS_STATE_EVENTS    8'h10
`define OFS_STATE_ENABLE    8'h14
`define OFS_USER_EVENTS     8'h18
`define OFS_CONTROL         8'h1C
`define OFS_SERIAL_POLL     8'h20
`define OFS_IRQ_STATUS      8'h24
`define OFS_IRQ_MASK        8'h28
`define OFS_STATE_QUERY     8'h2C

`define STB_SC_BIT          0
`define STB_MAV_BIT         4
`define STB_ESB_BIT         5
`define STB_RQS_BIT         6
`define ESR_USER_BIT        6
`define SC_ACQ_BIT          0
`define SC_LOCAL_BIT        2
`define CTRL_HDR_BIT        0
`define CTRL_CLS_BIT        1

`define IRQ_SRQ_BIT         0
`define IRQ_SC_BIT          1
`define IRQ_ESB_BIT         2

`define SRE_RESET           8'h00
`define ESE_RESET           8'h00
`define SC_MASK_RESET       16'h0000
`define CTRL_HDR_RESET      1'b1
`define IRQ_MASK_RESET      3'h0
`define QUERY_HDR_TAG       16'h0A5A

`endif

/* hdl/pin_sync.v */
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] pin,
   output reg  [W-1:0] level_ff,
   output wire [W-1:0] rise
);
   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;
   reg [W-1:0] nxt_level;
   reg [W-1:0] prev_ff;
   integer     i;

   // Level only moves where the second and third stages agree
   always @* begin
      nxt_level = level_ff;
      for (i = 0; i < W; i = i + 1) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_level[i] = s3_ff[i];
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         s1_ff    <= {W{1'b0}};
         s2_ff    <= {W{1'b0}};
         s3_ff    <= {W{1'b0}};
         level_ff <= {W{1'b0}};
         prev_ff  <= {W{1'b0}};
      end else begin
         s1_ff    <= pin;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         level_ff <= nxt_level;
         prev_ff  <= level_ff;
      end
   end

   assign rise = level_ff & ~prev_ff;
endmodule
`default_nettype wire

/* hdl/sticky_events.v */
// Sticky event register with clear, enable mask and summary
`timescale 1ns/1ps
`default_nettype none
module sticky_events #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] set,
   input  wire         clr,
   input  wire [W-1:0] mask,
   output reg  [W-1:0] events_ff,
   output wire         summary
);
   // Set wins over a clear in the same cycle
   wire [W-1:0] nxt_events = set | (clr ? {W{1'b0}} : events_ff);

   always @(posedge clk) begin
      if (rst) begin
         events_ff <= {W{1'b0}};
      end else begin
         events_ff <= nxt_events;
      end
   end

   assign summary = |(events_ff & mask);
endmodule
`default_nettype wire

/* hdl/service_request_status.v */
// Status byte, event registers and service request generation with Avalon-MM slave
//
// Behaviour
// - After reset the service request enable mask is zero, so no request.
// - Software writes the service request enable mask; it qualifies requests.
// - Request line rises once an enabled status byte bit becomes set.
// - Request bit stays latched until the status byte is read or polled, or a control write sets the clear bit.
// - Status byte read clears every bit but message-available at bit 4.
// - Enable mask of zero blocks every request.
// - Enabled state-change summary sits at status bit 0; mask value 1 enables it.
// - State-change bit 0 is new acquisition, bit 2 is local button.
// - State-change summary is OR of events gated by their enable bits.
// - User requests set standard event bit 6, never the status byte directly.
// - User request reaches status byte only with standard enable value 64.
// - Standard event summary sits at status bit 5; mask value 32 enables it.
// - Reading the state-change register returns it and clears it.
// - With header mode off, query answers carry the bare value.
// - Serial poll clears only the request bit of the status byte.
`include "srq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module service_request_status (
   input  wire        CLOCK,
   input  wire        RESET,
   input  wire [7:0]  ADDRESS,
   input  wire        READ,
   input  wire        WRITE,
   input  wire [31:0] WRITEDATA,
   input  wire [3:0]  BYTEENABLE,
   output reg  [31:0] READDATA,
   output reg         WAITREQUEST,
   input  wire        ACQ_DONE,
   input  wire        LOCAL_REQ,
   input  wire [7:0]  SOFT_KEY,
   input  wire [15:0] STATE_EVENT,
   input  wire [7:0]  STD_EVENT,
   input  wire        MSG_AVAIL,
   output reg         SRQ_OUT,
   output reg         RESP_HEADER,
   output reg         IRQ
);
   reg  [7:0]  sre_ff;
   reg  [7:0]  ese_ff;
   reg  [15:0] sc_mask_ff;
   reg  [2:0]  irq_mask_ff;
   reg  [2:0]  irq_stat_ff;
   reg         hdr_ff;
   reg         sc_sum_ff;
   reg         esb_ff;
   reg         rqs_ff;
   reg         req_prev_ff;
   reg         sc_prev_ff;
   reg         esb_prev_ff;
   reg         srq_prev_ff;
   reg  [31:0] rdata;
   reg         rd_stb;
   reg         rd_spoll;
   reg         rd_esr;
   reg         rd_sc;
   reg         rd_user;
   reg         rd_irq;
   reg         cls;
   wire        acc;
   wire        acc_rd;
   wire        acc_wr;
   wire        acq_rise;
   wire        local_rise;
   wire [7:0]  key_rise;
   wire [15:0] sc_set;
   wire [15:0] sc_q;
   wire        sc_any;
   wire [7:0]  user_q;
   wire [7:0]  esr_set;
   wire [7:0]  esr_q;
   wire        esr_sum;
   wire [7:0]  stb_view;
   wire        req_now;
   wire        nxt_sc_sum;
   wire        nxt_esb;
   wire        nxt_rqs;
   wire [2:0]  irq_ev;
   wire [2:0]  nxt_irq_stat;

   // Byte-lane write merge for the 8-bit masks
   function [7:0] wr8;
      input [7:0]  old;
      input [31:0] data;
      input [3:0]  be;
      begin
         wr8 = be[0] ? data[7:0] : old;
      end
   endfunction

   // Pins from the front panel and acquisition logic arrive asynchronously
   pin_sync #(.W(1)) u_acq_sync (
      .clk      (CLOCK),
      .rst      (RESET),
      .pin      (ACQ_DONE),
      .level_ff (),
      .rise     (acq_rise)
   );

   pin_sync #(.W(1)) u_local_sync (
      .clk      (CLOCK),
      .rst      (RESET),
      .pin      (LOCAL_REQ),
      .level_ff (),
      .rise     (local_rise)
   );

   pin_sync #(.W(8)) u_key_sync (
      .clk      (CLOCK),
      .rst      (RESET),
      .pin      (SOFT_KEY),
      .level_ff (),
      .rise     (key_rise)
   );

   // Acquisition and local-button events own fixed positions
   assign sc_set  = (STATE_EVENT & ~16'h0005)
                  | {15'h0000, acq_rise}
                  | {13'h0000, local_rise, 2'b00};

   sticky_events #(.W(16)) u_state_change_events (
      .clk       (CLOCK),
      .rst       (RESET),
      .set       (sc_set),
      .clr       (rd_sc | cls),
      .mask      (sc_mask_ff),
      .events_ff (sc_q),
      .summary   (sc_any)
   );

   sticky_events #(.W(8)) u_user_request_events (
      .clk       (CLOCK),
      .rst       (RESET),
      .set       (key_rise),
      .clr       (rd_user | cls),
      .mask      (8'hFF),
      .events_ff (user_q),
      .summary   ()
   );

   // User requests reach the status byte only through the standard event register
   assign esr_set = (STD_EVENT & ~8'h40) | {1'b0, (|key_rise), 6'h00};

   sticky_events #(.W(8)) u_std_events (
      .clk       (CLOCK),
      .rst       (RESET),
      .set       (esr_set),
      .clr       (rd_esr | cls),
      .mask      (ese_ff),
      .events_ff (esr_q),
      .summary   (esr_sum)
   );

   // A new enabled event sets the summary; a status read clears it
   assign nxt_sc_sum = (|(sc_set & sc_mask_ff)) | (sc_sum_ff & ~rd_stb & ~cls);
   assign nxt_esb = (|(esr_set & ese_ff)) | (esb_ff & ~rd_stb & ~cls);

   // Message-available follows its source live and survives reads
   assign stb_view = {1'b0, rqs_ff, esb_ff, MSG_AVAIL, 3'b000, sc_sum_ff};

   // Request bit is excluded from its own enable
   assign req_now = |(stb_view & sre_ff & ~8'h40);

   // Fresh rise sets the latch; set beats a same-cycle read clear
   assign nxt_rqs = (req_now & ~req_prev_ff)
                  | (rqs_ff & ~rd_stb & ~rd_spoll & ~cls);

   assign irq_ev = {esr_sum & ~esb_prev_ff,
                    sc_any & ~sc_prev_ff,
                    SRQ_OUT & ~srq_prev_ff};
   assign nxt_irq_stat = irq_ev | (rd_irq ? 3'h0 : irq_stat_ff);

   // One wait cycle, then the answer; side effects act at the first edge
   assign acc    = (READ | WRITE) & WAITREQUEST;
   assign acc_rd = acc & READ;
   assign acc_wr = acc & WRITE;

   always @* begin
      rdata    = 32'h00000000;
      rd_stb   = 1'b0;
      rd_spoll = 1'b0;
      rd_esr   = 1'b0;
      rd_sc    = 1'b0;
      rd_user  = 1'b0;
      rd_irq   = 1'b0;
      cls      = acc_wr & (ADDRESS == `OFS_CONTROL) & BYTEENABLE[0] & WRITEDATA[`CTRL_CLS_BIT];
      case (ADDRESS)
         `OFS_STATUS_BYTE: begin
            rdata  = {24'h000000, stb_view};
            rd_stb = acc_rd;
         end
         `OFS_SERIAL_POLL: begin
            rdata    = {24'h000000, stb_view};
            rd_spoll = acc_rd;
         end
         `OFS_SRQ_ENABLE: begin
            rdata = {24'h000000, sre_ff};
         end
         `OFS_STD_EVENT: begin
            rdata  = {24'h000000, esr_q};
            rd_esr = acc_rd;
         end
         `OFS_STD_ENABLE: begin
            rdata = {24'h000000, ese_ff};
         end
         `OFS_STATE_EVENTS: begin
            rdata = {16'h0000, sc_q};
            rd_sc = acc_rd;
         end
         `OFS_STATE_ENABLE: begin
            rdata = {16'h0000, sc_mask_ff};
         end
         `OFS_USER_EVENTS: begin
            rdata   = {24'h000000, user_q};
            rd_user = acc_rd;
         end
         `OFS_CONTROL: begin
            rdata = {30'h00000000, 1'b0, hdr_ff};
         end
         `OFS_IRQ_STATUS: begin
            rdata  = {29'h00000000, irq_stat_ff};
            rd_irq = acc_rd;
         end
         `OFS_IRQ_MASK: begin
            rdata = {29'h00000000, irq_mask_ff};
         end
         `OFS_STATE_QUERY: begin
            // Header tag only when header mode is on
            rdata = {(hdr_ff ? `QUERY_HDR_TAG : 16'h0000), sc_q};
            rd_sc = acc_rd;
         end
         default: begin
            rdata = 32'h00000000;
         end
      endcase
   end

   always @(posedge CLOCK) begin
      if (RESET) begin
         WAITREQUEST <= 1'b1;
         READDATA    <= 32'h00000000;
         sre_ff      <= `SRE_RESET;
         ese_ff      <= `ESE_RESET;
         sc_mask_ff  <= `SC_MASK_RESET;
         hdr_ff      <= `CTRL_HDR_RESET;
         irq_mask_ff <= `IRQ_MASK_RESET;
      end else begin
         WAITREQUEST <= ~acc;
         if (acc_rd) begin
            READDATA <= rdata;
         end
         if (acc_wr) begin
            case (ADDRESS)
               `OFS_SRQ_ENABLE: begin
                  sre_ff <= wr8(sre_ff, WRITEDATA, BYTEENABLE);
               end
               `OFS_STD_ENABLE: begin
                  ese_ff <= wr8(ese_ff, WRITEDATA, BYTEENABLE);
               end
               `OFS_STATE_ENABLE: begin
                  sc_mask_ff <= {wr8(sc_mask_ff[15:8], {24'h000000, WRITEDATA[15:8]}, {3'b000, BYTEENABLE[1]}),
                                 wr8(sc_mask_ff[7:0], WRITEDATA, BYTEENABLE)};
               end
               `OFS_CONTROL: begin
                  if (BYTEENABLE[0]) begin
                     hdr_ff <= WRITEDATA[`CTRL_HDR_BIT];
                  end
               end
               `OFS_IRQ_MASK: begin
                  if (BYTEENABLE[0]) begin
                     irq_mask_ff <= WRITEDATA[2:0];
                  end
               end
               default: begin
                  hdr_ff <= hdr_ff;
               end
            endcase
         end
      end
   end

   always @(posedge CLOCK) begin
      if (RESET) begin
         sc_sum_ff   <= 1'b0;
         esb_ff      <= 1'b0;
         rqs_ff      <= 1'b0;
         req_prev_ff <= 1'b0;
         sc_prev_ff  <= 1'b0;
         esb_prev_ff <= 1'b0;
         srq_prev_ff <= 1'b0;
         irq_stat_ff <= 3'h0;
         SRQ_OUT     <= 1'b0;
         RESP_HEADER <= 1'b1;
         IRQ         <= 1'b0;
      end else begin
         sc_sum_ff   <= nxt_sc_sum;
         esb_ff      <= nxt_esb;
         rqs_ff      <= nxt_rqs;
         req_prev_ff <= req_now;
         sc_prev_ff  <= sc_any;
         esb_prev_ff <= esr_sum;
         srq_prev_ff <= SRQ_OUT;
         irq_stat_ff <= nxt_irq_stat;
         // Line held while latched and some enabled bit still pending
         SRQ_OUT     <= nxt_rqs & req_now;
         RESP_HEADER <= hdr_ff;
         IRQ         <= |(nxt_irq_stat & irq_mask_ff);
      end
   end
endmodule
`default_nettype wire

/* verif/host_ctrl.sv */
// Bus controller model: Avalon master, serial poll, acquisition wait
`include "srq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module host_ctrl (
   input  wire logic        clk,
   input  wire logic        waitrequest,
   input  wire logic [31:0] readdata,
   input  wire logic        srq,
   output var  logic [7:0]  address,
   output var  logic        read,
   output var  logic        write,
   output var  logic [31:0] writedata
);
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // Idle edge after release, so a strobe never toggles twice in one step
   task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      address <= a;
      write <= w;
      read <= ~w;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic poll(output logic [31:0] q);
      while (srq !== 1'b1) @(posedge clk);
      access(`OFS_SERIAL_POLL, 1'b0, 32'h0, q);
   endtask
   // Continuous poll; reading also clears, so no separate clear access
   task automatic wait_acq(output logic [31:0] q);
      q = 32'h0;
      while (q[0] !== 1'b1) access(`OFS_STATE_QUERY, 1'b0, 32'h0, q);
   endtask
endmodule
`default_nettype wire

/* verif/srq_chk.sv */
// Assertions on bus timing and service request behaviour
`include "srq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module srq_chk (
   input wire logic        CLOCK,
   input wire logic        RESET,
   input wire logic [7:0]  ADDRESS,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [31:0] READDATA,
   input wire logic        WAITREQUEST,
   input wire logic [15:0] STATE_EVENT,
   input wire logic        MSG_AVAIL,
   input wire logic        SRQ_OUT,
   input wire logic        RESP_HEADER
);
   logic [7:0] sre_ff;
   wire        rd_done = READ && !WAITREQUEST;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // Shadow taken at completion, so it lags the design
   always @(posedge CLOCK) begin
      if (RESET)
         sre_ff <= 8'h00;
      else if (WRITE && !WAITREQUEST && ADDRESS == `OFS_SRQ_ENABLE)
         sre_ff <= WRITEDATA[7:0];
   end
   chk_wait_one: assert property (
      (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
      else $error("wait state not one cycle");
   chk_sre_zero: assert property (
      sre_ff == 8'h00 && $past(sre_ff) == 8'h00 |-> !SRQ_OUT)
      else $error("request with zero mask");
   chk_srq_hold: assert property (
      (!READ && !WRITE)[*3] ##0 SRQ_OUT |=> SRQ_OUT)
      else $error("request dropped unread");
   chk_stb_read: assert property (
      rd_done && ADDRESS == `OFS_STATUS_BYTE |-> READDATA[31:8] == 24'h0 && READDATA[4] == $past(MSG_AVAIL))
      else $error("status byte read wrong");
   chk_srq_drop: assert property (
      rd_done && ADDRESS == `OFS_STATUS_BYTE && STATE_EVENT == 16'h0 && !sre_ff[4] |-> ##[0:2] !SRQ_OUT)
      else $error("request not released");
   chk_hdr_copy: assert property (
      WRITE && !WAITREQUEST && ADDRESS == `OFS_CONTROL |=> RESP_HEADER == $past(WRITEDATA[0]))
      else $error("header mode not applied");
   chk_query_hdr: assert property (
      rd_done && ADDRESS == `OFS_STATE_QUERY |-> READDATA[31:16] == (RESP_HEADER ? `QUERY_HDR_TAG : 16'h0))
      else $error("query header wrong");
   chk_poll_clr: assert property (
      rd_done && ADDRESS == `OFS_SERIAL_POLL && READDATA[6] |-> ##[0:1] !SRQ_OUT)
      else $error("poll left request up");
   cov_srq: cover property ($rose(SRQ_OUT));
   cov_poll: cover property (rd_done && ADDRESS == `OFS_SERIAL_POLL && READDATA[6]);
   cov_bare: cover property (rd_done && ADDRESS == `OFS_STATE_QUERY && !RESP_HEADER);
endmodule
bind service_request_status srq_chk srq_chk_inst (.CLOCK(CLOCK), .RESET(RESET), .ADDRESS(ADDRESS),
   .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
   .STATE_EVENT(STATE_EVENT), .MSG_AVAIL(MSG_AVAIL), .SRQ_OUT(SRQ_OUT), .RESP_HEADER(RESP_HEADER));
`default_nettype wire

/* verif/tb.sv */
// Directed testbench for the service request block
`include "srq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        acq = 1'b0;
   logic        loc = 1'b0;
   logic        mav = 1'b0;
   logic [7:0]  key = 8'h00;
   logic [15:0] sev = 16'h0000;
   logic [7:0]  addr;
   logic        rd;
   logic        wr_s;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wreq;
   logic        srq;
   logic        hdr;
   logic        irq;
   logic [31:0] q;
   int          fail_count = 0;
   int          comparisons = 0;
   always #5 clk = ~clk;
   service_request_status service_request_status_inst (.CLOCK(clk), .RESET(rst), .ADDRESS(addr),
      .READ(rd), .WRITE(wr_s), .WRITEDATA(wdata), .BYTEENABLE(4'hF), .READDATA(rdata), .WAITREQUEST(wreq),
      .ACQ_DONE(acq), .LOCAL_REQ(loc), .SOFT_KEY(key), .STATE_EVENT(sev), .STD_EVENT(8'h00),
      .MSG_AVAIL(mav), .SRQ_OUT(srq), .RESP_HEADER(hdr), .IRQ(irq));
   host_ctrl host_ctrl_inst (.clk(clk), .waitrequest(wreq), .readdata(rdata), .srq(srq),
      .address(addr), .read(rd), .write(wr_s), .writedata(wdata));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_ctrl_inst.access(a, 1'b1, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      host_ctrl_inst.access(a, 1'b0, 32'h0, q);
      chk($sformatf("reg %h", a), q, e);
   endtask
   // Pins pass a synchroniser, so wait well past its four edges
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_acq;
      chk("srq", srq, 1'b0);
      rc(`OFS_SRQ_ENABLE, 32'h0);
      rc(8'h30, 32'h0);
      wr(`OFS_IRQ_MASK, 32'h3);
      wr(`OFS_STATE_ENABLE, 32'h5);
      wr(`OFS_SRQ_ENABLE, 32'h1);
      rc(`OFS_SRQ_ENABLE, 32'h1);
      acq <= 1'b1;
      host_ctrl_inst.wait_acq(q);
      chk("query", q, {`QUERY_HDR_TAG, 16'h0001});
      cyc(4);
      chk("srq", srq, 1'b1);
      chk("irq", irq, 1'b1);
      acq <= 1'b0;
      mav <= 1'b1;
      cyc(12);
      chk("srq held", srq, 1'b1);
      host_ctrl_inst.poll(q);
      chk("poll", q, 32'h51);
      rc(`OFS_STATUS_BYTE, 32'h11);
      rc(`OFS_STATUS_BYTE, 32'h10);
      chk("srq", srq, 1'b0);
      rc(`OFS_IRQ_STATUS, 32'h3);
      chk("irq", irq, 1'b0);
      mav <= 1'b0;
      $display("acquisition test done");
   endtask
   task automatic t_mask;
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_STATE_ENABLE, 32'h4);
      sev <= 16'h0002;
      @(posedge clk);
      sev <= 16'h0000;
      rc(`OFS_STATUS_BYTE, 32'h0);
      rc(`OFS_STATE_EVENTS, 32'h2);
      rc(`OFS_STATE_EVENTS, 32'h0);
      wr(`OFS_SRQ_ENABLE, 32'h0);
      wr(`OFS_STATE_ENABLE, 32'h5);
      loc <= 1'b1;
      cyc(12);
      loc <= 1'b0;
      chk("srq", srq, 1'b0);
      chk("irq", irq, 1'b0);
      rc(`OFS_STATUS_BYTE, 32'h1);
      rc(`OFS_STATE_EVENTS, 32'h4);
      rc(`OFS_IRQ_STATUS, 32'h2);
      $display("mask test done");
   endtask
   task automatic t_user;
      wr(`OFS_SRQ_ENABLE, 32'h20);
      key <= 8'h02;
      cyc(12);
      key <= 8'h00;
      chk("srq", srq, 1'b0);
      rc(`OFS_STATUS_BYTE, 32'h0);
      rc(`OFS_STD_EVENT, 32'h40);
      rc(`OFS_USER_EVENTS, 32'h2);
      wr(`OFS_STD_ENABLE, 32'h40);
      key <= 8'h80;
      cyc(12);
      key <= 8'h00;
      chk("srq", srq, 1'b1);
      chk("irq", irq, 1'b1);
      rc(`OFS_STATUS_BYTE, 32'h60);
      rc(`OFS_IRQ_STATUS, 32'h5);
      chk("srq", srq, 1'b0);
      $display("user test done");
   endtask
   task automatic t_hdr;
      chk("hdr", hdr, 1'b1);
      wr(`OFS_CONTROL, 32'h0);
      cyc(2);
      chk("hdr", hdr, 1'b0);
      sev <= 16'h0008;
      @(posedge clk);
      sev <= 16'h0000;
      rc(`OFS_STATE_QUERY, 32'h8);
      key <= 8'h01;
      cyc(12);
      key <= 8'h00;
      chk("srq", srq, 1'b1);
      wr(`OFS_CONTROL, 32'h2);
      chk("srq", srq, 1'b0);
      rc(`OFS_STD_EVENT, 32'h0);
      rc(`OFS_USER_EVENTS, 32'h0);
      rc(`OFS_STATUS_BYTE, 32'h0);
      wr(`OFS_CONTROL, 32'h1);
      $display("header test done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_acq();
      t_mask();
      t_user();
      t_hdr();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
